// ---- logic/imc_defines.svh ----
// Function
// - Bit 9 selects 32-bit or 16-bit bursts.
// - Readback of changed bits lags up to 200 us, 250 ms for bit 4, until the next sample for mode or multiplier.
// - Bit 8 selects delta or rate burst content.
// - Bit 7 enables gyro linear-acceleration correction.
// - Bit 6 enables accelerometer corner relocation.
// - Bit 4 bandwidth; change reinitialises up to 250 ms.
// - Narrow bandwidth adds fixed group delays.
// - Timing mode 00 samples on internal 2 kHz.
// - Mode 10: slow trigger multiplied up internally.
// - Mode 11: internal timing, trigger pin outputs.
// - Bit 1 sets trigger pin active edge.
// - Bit 0 sets data-ready pin polarity.
// - Register resets to 0x00C1.
// - Scaled rate is trigger rate times multiplier.
`ifndef IMC_DEFINES_SVH
`define IMC_DEFINES_SVH
`define IMC_CLK_MHZ      100
`define IMC_CTRL_LO      7'h60
`define IMC_CTRL_HI      7'h61
`define IMC_SCALE_LO     7'h62
`define IMC_SCALE_HI     7'h63
`define IMC_CTRL_RESET   16'h00c1
`define IMC_CTRL_MASK    16'h03df
`define IMC_SCALE_RESET  16'h07d0
`define IMC_B_WIDE       9
`define IMC_B_DELTA      8
`define IMC_B_LINCOMP    7
`define IMC_B_CORNER     6
`define IMC_B_BW         4
`define IMC_B_SYNC_HI    3
`define IMC_B_SYNC_LO    2
`define IMC_B_SYNC_POL   1
`define IMC_B_DR_POL     0
`define IMC_REFLECT_US   200
`define IMC_REINIT_MS    250
`define IMC_INT_HZ       2000
`define IMC_GYRO_DLY_US  170
`define IMC_ACCEL_DLY_US 630
`define IMC_DR_US        2
`define IMC_CNT_W        25
`define IMC_WORD_LAST    5'h0f
`endif

// ---- logic/imc_pkg.sv ----
package imc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_REFLECT, ST_REINIT} imc_settle_t;
  typedef enum logic [1:0] {
    SYNC_INT, SYNC_DIRECT, SYNC_SCALED, SYNC_OUTPUT
  } imc_sync_t;
endpackage

// ---- logic/imc_misc_control.sv ----
`timescale 1ns/1ps
`include "imc_defines.svh"
module imc_misc_control #(
  parameter int REFLECT_CYC = `IMC_REFLECT_US * `IMC_CLK_MHZ,
  parameter int REINIT_CYC  = `IMC_REINIT_MS * 1000 * `IMC_CLK_MHZ,
  parameter int INT_CYC     = `IMC_CLK_MHZ * 1000000 / `IMC_INT_HZ
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  // Serial command port
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_cs_b_in,
  input  wire logic        spi_din_in,
  output logic             spi_dout_out,
  // Sampling trigger pin
  input  wire logic        sync_pin_in,
  output logic             sync_pin_out,
  output logic             sync_pin_oe_b_out,
  // Data ready and sampling
  output logic             data_ready_out,
  output logic             sample_tick_out,
  // Settings to the signal path
  output logic             burst_wide_words_out,
  output logic             burst_delta_out,
  output logic             lin_accel_comp_out,
  output logic             corner_reloc_out,
  output logic             sensor_bandwidth_select_out,
  output logic [1:0]       sync_mode_out,
  output logic [15:0]      gyro_delay_cyc_out,
  output logic [15:0]      accel_delay_cyc_out
);
  localparam int DR_CYC    = `IMC_DR_US * `IMC_CLK_MHZ;
  localparam int GYRO_CYC  = `IMC_GYRO_DLY_US * `IMC_CLK_MHZ;
  localparam int ACCEL_CYC = `IMC_ACCEL_DLY_US * `IMC_CLK_MHZ;
  localparam int CW        = `IMC_CNT_W;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic       rst_s1_q;
  logic       rst_n_q;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end

  always_ff @(posedge ref_clk_in or negedge rst_n_q)
    if (!rst_n_q)
    begin
      pin_s1_q <= 4'h3;
      pin_s2_q <= 4'h3;
      pin_s3_q <= 4'h3;
    end
    else
    begin
      pin_s1_q <= {sync_pin_in, spi_din_in, spi_cs_b_in, spi_sclk_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end

  wire sclk_rise = pin_s2_q[0] & ~pin_s3_q[0];
  wire sclk_fall = ~pin_s2_q[0] & pin_s3_q[0];
  wire cs_b      = pin_s2_q[1];
  wire cs_fall   = ~pin_s2_q[1] & pin_s3_q[1];
  wire din       = pin_s2_q[2];
  wire sync_rise = pin_s2_q[3] & ~pin_s3_q[3];
  wire sync_fall = ~pin_s2_q[3] & pin_s3_q[3];

  // ----------------------------------------------------------------
  // Serial command words
  // ----------------------------------------------------------------
  logic [4:0]  bit_q;
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [15:0] reply_q;
  logic [15:0] ctrl_q;
  logic [15:0] shown_q;
  logic [15:0] scale_q;

  function automatic logic [15:0] rd_word(input logic [6:0] a);
    if (a == `IMC_CTRL_LO || a == `IMC_CTRL_HI)
      return shown_q;
    else if (a == `IMC_SCALE_LO || a == `IMC_SCALE_HI)
      return scale_q;
    else
      return 16'h0000;
  endfunction

  wire        word_done = sclk_rise & ~cs_b & (bit_q == `IMC_WORD_LAST);
  wire [15:0] word      = {rx_q[14:0], din};
  wire [6:0]  waddr     = word[14:8];
  wire        wr        = word_done & word[15];
  wire        wr_c_lo   = wr & (waddr == `IMC_CTRL_LO);
  wire        wr_c_hi   = wr & (waddr == `IMC_CTRL_HI);
  wire        wr_s_lo   = wr & (waddr == `IMC_SCALE_LO);
  wire        wr_s_hi   = wr & (waddr == `IMC_SCALE_HI);

  always_ff @(posedge ref_clk_in or negedge rst_n_q)
    if (!rst_n_q)
    begin
      bit_q   <= 5'h00;
      rx_q    <= 16'h0000;
      tx_q    <= 16'h0000;
      reply_q <= 16'h0000;
    end
    else
    begin
      if (cs_b)
        bit_q <= 5'h00;
      else if (sclk_rise)
        bit_q <= bit_q + 5'h01;
      if (sclk_rise & ~cs_b)
        rx_q <= word;
      // The first falling edge only opens the frame, bit 15 is already out.
      if (cs_fall)
        tx_q <= reply_q;
      else if (sclk_fall & ~cs_b & (bit_q != 5'h00))
        tx_q <= {tx_q[14:0], 1'b0};
      if (word_done & ~word[15])
        reply_q <= rd_word(waddr);
    end

  assign spi_dout_out = tx_q[15];

  // ----------------------------------------------------------------
  // Control and multiplier registers
  // ----------------------------------------------------------------
  wire [15:0] ctrl_d = (wr_c_lo ? {ctrl_q[15:8], word[7:0]}
                     : wr_c_hi ? {word[7:0], ctrl_q[7:0]}
                     : ctrl_q) & `IMC_CTRL_MASK;
  wire [15:0] scale_d = wr_s_lo ? {scale_q[15:8], word[7:0]}
                      : wr_s_hi ? {word[7:0], scale_q[7:0]} : scale_q;
  wire bw_chg   = ctrl_d[`IMC_B_BW] != ctrl_q[`IMC_B_BW];
  wire sync_chg = (ctrl_d[3:2] != ctrl_q[3:2]) | (scale_d != scale_q);
  wire any_chg  = ctrl_d != ctrl_q;

  always_ff @(posedge ref_clk_in or negedge rst_n_q)
    if (!rst_n_q)
    begin
      ctrl_q  <= `IMC_CTRL_RESET;
      scale_q <= `IMC_SCALE_RESET;
    end
    else
    begin
      ctrl_q  <= ctrl_d;
      scale_q <= scale_d;
    end

  // ----------------------------------------------------------------
  // Readback settling and sensor reinitialisation
  // ----------------------------------------------------------------
  imc_pkg::imc_settle_t st_q;
  logic [CW-1:0]        cnt_q;
  logic                 sync_wait_q;
  logic                 tick_q;

  wire reinit = st_q == imc_pkg::ST_REINIT;

  always_ff @(posedge ref_clk_in or negedge rst_n_q)
    if (!rst_n_q)
    begin
      st_q        <= imc_pkg::ST_IDLE;
      cnt_q       <= '0;
      shown_q     <= `IMC_CTRL_RESET;
      sync_wait_q <= 1'b0;
    end
    else
    begin
      if (sync_chg)
        sync_wait_q <= 1'b1;
      else if (tick_q)
        sync_wait_q <= 1'b0;
      if (bw_chg)
      begin
        st_q  <= imc_pkg::ST_REINIT;
        cnt_q <= CW'(REINIT_CYC - 1);
      end
      else if (any_chg && !reinit)
      begin
        st_q  <= imc_pkg::ST_REFLECT;
        cnt_q <= CW'(REFLECT_CYC - 1);
      end
      else
        case (st_q)
          imc_pkg::ST_IDLE:
            if (!sync_wait_q)
              shown_q <= ctrl_q;
          imc_pkg::ST_REFLECT, imc_pkg::ST_REINIT:
            if (cnt_q == '0)
              st_q <= imc_pkg::ST_IDLE;
            else
              cnt_q <= cnt_q - 1'b1;
          default:
            st_q <= imc_pkg::ST_IDLE;
        endcase
    end

  // ----------------------------------------------------------------
  // Sampling timing sources
  // ----------------------------------------------------------------
  logic [15:0] int_q;
  logic [31:0] per_q;
  logic [31:0] per_last_q;
  logic [31:0] acc_q;

  wire [1:0] mode     = ctrl_q[`IMC_B_SYNC_HI:`IMC_B_SYNC_LO];
  wire       pol      = ctrl_q[`IMC_B_SYNC_POL];
  wire       ext_edge = pol ? sync_rise : sync_fall;
  wire       int_tick = int_q == 16'(INT_CYC - 1);
  wire [31:0] acc_sum = acc_q + {16'h0000, scale_q};
  wire scl_tick = (per_last_q != 32'h0) && (acc_sum >= per_last_q);
  wire tick = (mode == imc_pkg::SYNC_DIRECT) ? ext_edge
            : (mode == imc_pkg::SYNC_SCALED) ? scl_tick
            : int_tick;

  always_ff @(posedge ref_clk_in or negedge rst_n_q)
    if (!rst_n_q)
    begin
      int_q      <= 16'h0000;
      per_q      <= 32'h0;
      per_last_q <= 32'h0;
      acc_q      <= 32'h0;
    end
    else
    begin
      int_q <= int_tick ? 16'h0000 : int_q + 16'h0001;
      if (ext_edge)
      begin
        per_last_q <= per_q + 32'h1;
        per_q      <= 32'h0;
        acc_q      <= 32'h0;
      end
      else
      begin
        per_q <= per_q + 32'h1;
        acc_q <= scl_tick ? acc_sum - per_last_q : acc_sum;
      end
    end

  // ----------------------------------------------------------------
  // Data ready, trigger output and burst format
  // ----------------------------------------------------------------
  logic [15:0] dr_q;
  logic [1:0]  burst_q;
  logic        dr_out_q;
  logic        sync_out_q;
  logic        sync_oe_b_q;

  wire dr_act = dr_q != 16'h0000;

  always_ff @(posedge ref_clk_in or negedge rst_n_q)
    if (!rst_n_q)
    begin
      tick_q      <= 1'b0;
      dr_q        <= 16'h0000;
      burst_q     <= 2'b00;
      dr_out_q    <= 1'b1;
      sync_out_q  <= 1'b1;
      sync_oe_b_q <= 1'b1;
    end
    else
    begin
      tick_q <= tick & ~reinit & ~bw_chg;
      if (tick_q)
      begin
        dr_q    <= 16'(DR_CYC);
        burst_q <= ctrl_q[`IMC_B_WIDE:`IMC_B_DELTA];
      end
      else if (dr_act)
        dr_q <= dr_q - 16'h0001;
      dr_out_q    <= dr_act ~^ ctrl_q[`IMC_B_DR_POL];
      sync_out_q  <= dr_act ~^ pol;
      sync_oe_b_q <= mode != imc_pkg::SYNC_OUTPUT;
    end

  assign data_ready_out       = dr_out_q;
  assign sample_tick_out      = tick_q;
  assign sync_pin_out         = sync_out_q;
  assign sync_pin_oe_b_out    = sync_oe_b_q;
  assign burst_wide_words_out = burst_q[1];
  assign burst_delta_out      = burst_q[0];
  assign lin_accel_comp_out   = ctrl_q[`IMC_B_LINCOMP];
  assign corner_reloc_out     = ctrl_q[`IMC_B_CORNER];
  assign sensor_bandwidth_select_out = ctrl_q[`IMC_B_BW];
  assign sync_mode_out        = mode;
  assign gyro_delay_cyc_out   = ctrl_q[`IMC_B_BW] ? 16'(GYRO_CYC)
                              : 16'h0000;
  assign accel_delay_cyc_out  = ctrl_q[`IMC_B_BW] ? 16'(ACCEL_CYC)
                              : 16'h0000;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_q);

  sequence s_bw_write;
    bw_chg;
  endsequence
  sequence s_quiet;
    !tick_q [*8];
  endsequence

  reset_value_a: assert property ($rose(rst_n_q) |-> ctrl_q == 16'h00c1)
    else $error("control register reset value wrong");
  unused_zero_a: assert property ((ctrl_q & 16'hfc20) == 16'h0000)
    else $error("unused control bits not zero");
  readback_lag_a: assert property (any_chg && !bw_chg && !reinit
      |=> (st_q == imc_pkg::ST_REFLECT) && shown_q == $past(shown_q))
    else $error("readback changed before settling");
  reinit_quiet_a: assert property (s_bw_write |=> s_quiet)
    else $error("sampling during sensor reinit");
  burst_at_tick_a: assert property (!$past(tick_q)
      |-> burst_q == $past(burst_q))
    else $error("burst format changed off a sample");
  dr_polarity_a: assert property (tick_q ##1 1 |=>
      data_ready_out == ctrl_q[0])
    else $error("data ready polarity wrong");
  sync_drive_a: assert property (!sync_oe_b_q |-> $past(mode) == 2'b11)
    else $error("trigger pin driven outside output mode");
  int_period_a: assert property ((mode == 2'b00) && int_tick && !reinit
      && !bw_chg |=> tick_q)
    else $error("internal tick not taken");
  gyro_delay_a: assert property (ctrl_q[4] |->
      gyro_delay_cyc_out == 16'h4268 && accel_delay_cyc_out == 16'hf618)
    else $error("group delay figures wrong");
endmodule

// ---- test/imc_host_model.sv ----
`timescale 1ns/1ps
`include "imc_defines.svh"
module imc_host_model (
  // Clock
  input  wire logic ref_clk_in,
  // Serial lines
  output logic      spi_sclk_out,
  output logic      spi_cs_b_out,
  output logic      spi_din_out,
  input  wire logic spi_dout_in
);
  // --------------------------------------------------------------
  // Serial master
  // --------------------------------------------------------------
  initial
  begin
    spi_sclk_out = 1'b1;
    spi_cs_b_out = 1'b1;
    spi_din_out  = 1'b0;
  end

  task automatic half;
    repeat (4) @(negedge ref_clk_in);
  endtask

  // Clock idles high; the reply bit is taken on each rising edge.
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    spi_cs_b_out = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      half();
      spi_sclk_out = ~spi_sclk_out;
      spi_din_out  = tx[i];
      half();
      spi_sclk_out = ~spi_sclk_out;
      rx[i]        = spi_dout_in;
    end
    half();
    spi_cs_b_out = 1'b1;
    spi_din_out  = ~tx[0];
    half();
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] junk;
    xfer({1'b1, a, d}, junk);
  endtask

  // The reply to a read word arrives in the following frame.
  task automatic rd(input logic [6:0] a, output logic [15:0] q);
    logic [15:0] junk;
    xfer({1'b0, a, 8'h00}, junk);
    xfer(16'h0000, q);
  endtask

  task automatic wr_ctrl(input logic [15:0] v);
    wr(`IMC_CTRL_LO, v[7:0] & 8'hdf);
    wr(`IMC_CTRL_HI, v[15:8]);
  endtask
endmodule

// ---- test/tb_imc_misc_control.sv ----
`timescale 1ns/1ps
`include "imc_defines.svh"
module tb_imc_misc_control;
  localparam int REFLECT = 20;
  localparam int INTC    = 100;
  logic        ref_clk_in, rst_b_in, sclk, cs_b, din, dout;
  logic        sync_tb, sync_wire, sync_out, sync_oe_b, dr, tick;
  logic        wide, delta, lin, corner, bw;
  logic [1:0]  mode;
  logic [15:0] gdly, adly, rdv;
  logic [9:0]  view;
  int          num_errors, check_count, cyc, n;

  assign sync_wire = sync_oe_b ? sync_tb : sync_out;
  assign view      = {wide, delta, lin, corner, 1'b0, bw, mode, 2'b00};

  imc_misc_control #(.REFLECT_CYC(REFLECT), .REINIT_CYC(50),
    .INT_CYC(INTC)) u_imc_misc_control (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .spi_sclk_in(sclk), .spi_cs_b_in(cs_b), .spi_din_in(din),
    .spi_dout_out(dout), .sync_pin_in(sync_wire),
    .sync_pin_out(sync_out), .sync_pin_oe_b_out(sync_oe_b),
    .data_ready_out(dr), .sample_tick_out(tick),
    .burst_wide_words_out(wide), .burst_delta_out(delta),
    .lin_accel_comp_out(lin), .corner_reloc_out(corner),
    .sensor_bandwidth_select_out(bw), .sync_mode_out(mode),
    .gyro_delay_cyc_out(gdly), .accel_delay_cyc_out(adly)
  );

  imc_host_model u_imc_host_model (
    .ref_clk_in(ref_clk_in), .spi_sclk_out(sclk), .spi_cs_b_out(cs_b),
    .spi_din_out(din), .spi_dout_in(dout)
  );

  // --------------------------------------------------------------
  // Clock, timeout and checking
  // --------------------------------------------------------------
  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk_word(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, g);
    chk_word(nm, {15'h0000, e}, {15'h0000, g});
  endtask

  // Waits for a sample, then one cycle; data ready only follows a cycle after that.
  task automatic wait_tick;
    n = 0;
    do
    begin
      @(negedge ref_clk_in);
      n++;
    end
    while (tick !== 1'b1 && n < 400);
    chk_bit("sample tick", 1'b1, tick);
    @(negedge ref_clk_in);
  endtask

  task automatic edge_ticks(input logic v, input int w, input logic [15:0] e);
    sync_tb = v;
    n = 0;
    repeat (w)
    begin
      @(negedge ref_clk_in);
      if (tick === 1'b1)
        n++;
    end
    chk_word("tick count", e, n[15:0]);
  endtask

  task automatic end_test(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial
  begin
    rst_b_in = 1'b0;
    sync_tb  = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    rst_b_in = 1'b1;
    repeat (5) @(negedge ref_clk_in);
    chk_word("settings", 16'h00c0, {6'h00, view});
    chk_word("gyro delay", 16'h0000, gdly);
    u_imc_host_model.rd(`IMC_CTRL_LO, rdv);
    chk_word("control", 16'h00c1, rdv);
    wait_tick();
    wait_tick();
    chk_word("tick gap", INTC - 1, n[15:0]);
    chk_bit("ready level", 1'b1, dr);
    end_test("reset");
    u_imc_host_model.wr_ctrl(16'h0081);
    repeat (3) @(negedge ref_clk_in);
    chk_word("settings", 16'h0080, {6'h00, view});
    repeat (REFLECT) @(negedge ref_clk_in);
    u_imc_host_model.rd(`IMC_CTRL_LO, rdv);
    chk_word("control", 16'h0081, rdv);
    end_test("relocation off");
    u_imc_host_model.wr_ctrl(16'h0086);
    edge_ticks(1'b1, 12, 16'h0001);
    chk_bit("ready level", 1'b0, dr);
    edge_ticks(1'b0, 12, 16'h0000);
    u_imc_host_model.wr_ctrl(16'h0084);
    edge_ticks(1'b1, 12, 16'h0000);
    edge_ticks(1'b0, 12, 16'h0001);
    end_test("direct trigger");
    u_imc_host_model.wr_ctrl(16'h008d);
    repeat (3) @(negedge ref_clk_in);
    chk_bit("pin enable", 1'b0, sync_oe_b);
    wait_tick();
    wait_tick();
    chk_word("tick gap", INTC - 1, n[15:0]);
    chk_bit("ready level", 1'b1, dr);
    chk_bit("trigger pin", 1'b0, sync_out);
    end_test("output trigger");
    u_imc_host_model.wr(`IMC_SCALE_LO, 8'h04);
    u_imc_host_model.wr(`IMC_SCALE_HI, 8'h00);
    u_imc_host_model.wr_ctrl(16'h0089);
    n = 0;
    for (int k = 0; k < 6; k++)
    begin
      sync_tb = ~sync_tb;
      repeat (200)
      begin
        @(negedge ref_clk_in);
        if (k > 3 && tick === 1'b1)
          n++;
      end
    end
    chk_bit("scaled rate", 1'b1, n >= 3 && n <= 5);
    end_test("scaled trigger");
    u_imc_host_model.wr(`IMC_CTRL_LO, 8'hd1);
    repeat (3) @(negedge ref_clk_in);
    chk_bit("bandwidth", 1'b1, bw);
    chk_word("gyro delay", 16'h4268, gdly);
    chk_word("accel delay", 16'hf618, adly);
    edge_ticks(sync_tb, 40, 16'h0000);
    wait_tick();
    u_imc_host_model.wr(`IMC_CTRL_HI, 8'hff);
    chk_bit("wide words", 1'b0, wide);
    wait_tick();
    chk_word("settings", 16'h03d0, {6'h00, view});
    repeat (REFLECT) @(negedge ref_clk_in);
    u_imc_host_model.rd(`IMC_CTRL_LO, rdv);
    chk_word("control", 16'h03d1, rdv);
    u_imc_host_model.wr(7'h70, 8'h5a);
    u_imc_host_model.rd(7'h70, rdv);
    chk_word("unmapped", 16'h0000, rdv);
    end_test("burst and bandwidth");
    rst_b_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    rst_b_in = 1'b1;
    repeat (5) @(negedge ref_clk_in);
    chk_word("settings", 16'h00c0, {6'h00, view});
    end_test("second reset");
    finish_test();
  end
endmodule
